// ### logic/timer_capture_interrupt_flags.sv
// Timer with compare/capture channels, interrupt flags and enables.
// Assumes a single-cycle register port and synchronous capture inputs.
//
// Notes on behaviour
// R1: Match or valid capture sets channel flag.
// R2: Flag sets two clocks after tick, gated by enable.
// R3: Write one clears channel flag, zero keeps.
// R4: Reading capture value clears channel flag.
// R5: Capture onto set flag raises error flag.
// R6: Write one clears error flag.
// R7: Set register one enables error interrupt.
// R8: Set register one enables overflow interrupt.
// R9: Channel enable bits read back state.
// R10: Byte, half and word accesses accepted.
// R11: Each byte and half reachable directly.
// R12: Protected registers ignore writes when locked.
// R13: Synchronized registers update on counter tick.
// R14: Enable-protected registers written only disabled.
// R15: Interrupt high while enabled flag set.
// R16: Clear register one disables interrupt.
// R17: Counter wrap sets overflow flag.
// R18: Reset and software reset zero flags.
`default_nettype none
module timer_capture_interrupt_flags (
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  input  wire logic [timer_pkg::ADDR_W-1:0] addr,
  input  wire logic [timer_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                   byte_en,
  input  wire logic                         wr_stb,
  input  wire logic                         rd_stb,
  output logic [timer_pkg::DATA_W-1:0]      rdata,
  input  wire logic                         write_protect,
  input  wire logic [timer_pkg::NUM_CH-1:0] capture_in,
  output logic                              irq
);
  import timer_pkg::*;

  logic [ADDR_W-1:0] lane_addr [4];
  logic [3:0]        lane_wr, lane_rd;
  logic [7:0]        lane_data [4];

  logic              enable_q, enable_d, soft_q, soft_d;
  logic [NUM_CH-1:0] capt_mode_q, capt_mode_d;
  logic [7:0]        int_en_q, int_en_d, flag_q, flag_d;
  logic [CNT_W-1:0]  count_q, count_d, cnt_pend_q, cnt_pend_d;
  logic [DIV_W-1:0]  div_q, div_d;
  logic              tick_q, tick_d, irq_q, irq_d, ovf_hit;
  sync_state_t       sync_q, sync_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  logic [NUM_CH-1:0] match_hit, overrun, cc_busy, rd_cc, cc_wr_lo, cc_wr_hi;
  logic [CNT_W-1:0]  cc_value [NUM_CH], cc_wdata [NUM_CH];
  logic              wr_main, wr_capt_raw, wr_capt, wr_clr, wr_set;
  logic              wr_flag, wr_cnt_lo, wr_cnt_hi, rd_set;
  logic [7:0]        wb_main, wb_capt, wb_clr, wb_set, wb_flag;
  logic [7:0]        wb_cnt_lo, wb_cnt_hi;

  // R10 split access into lanes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_addr[i] = {addr[ADDR_W-1:2], 2'(i)};
      lane_wr[i]   = wr_stb & byte_en[i];
      lane_rd[i]   = rd_stb & byte_en[i];
      lane_data[i] = wdata[8*i +: 8];
    end
  end

  function automatic logic wr_at(input logic [ADDR_W-1:0] ofs);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      hit = hit | (lane_wr[i] & (lane_addr[i] == ofs));
    end
    return hit;
  endfunction

  function automatic logic rd_at(input logic [ADDR_W-1:0] ofs);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      hit = hit | (lane_rd[i] & (lane_addr[i] == ofs));
    end
    return hit;
  endfunction

  function automatic logic [7:0] wbyte_at(input logic [ADDR_W-1:0] ofs);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (lane_addr[i] == ofs) begin
        b = lane_data[i];
      end
    end
    return b;
  endfunction

  function automatic logic [7:0] reg_byte(input logic [ADDR_W-1:0] ofs);
    logic [7:0] b;
    b = 8'h00;
    unique case (ofs)
      OFS_CTRL_MAIN: b[BIT_ENABLE] = enable_q;
      OFS_CTRL_CAPT: b[NUM_CH-1:0] = capt_mode_q;
      OFS_IRQ_CLR:   b = int_en_q;
      OFS_IRQ_SET:   b = int_en_q;
      OFS_IRQ_FLAG:  b = flag_q;
      OFS_STATUS:    b[BIT_SYNC_BUSY] = (sync_q == SYNC_WAIT) | (|cc_busy);
      OFS_COUNT_LO:  b = count_q[7:0];
      OFS_COUNT_HI:  b = count_q[15:8];
      default: begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (ofs == OFS_CC_BASE + ADDR_W'(2 * c)) begin
            b = cc_value[c][7:0];
          end
          if (ofs == OFS_CC_BASE + ADDR_W'(2 * c + 1)) begin
            b = cc_value[c][15:8];
          end
        end
      end
    endcase
    return b;
  endfunction

  // Decodes sit in a process so that the lane signals the helper
  // functions read are part of its sensitivity.
  always_comb begin
    // R12 locked registers drop writes
    wr_main     = wr_at(OFS_CTRL_MAIN) & !write_protect;
    wr_capt_raw = wr_at(OFS_CTRL_CAPT);
    // R14 capture modes fixed while enabled
    wr_capt     = wr_capt_raw & !write_protect & !enable_q;
    wr_clr      = wr_at(OFS_IRQ_CLR);
    wr_set      = wr_at(OFS_IRQ_SET);
    wr_flag     = wr_at(OFS_IRQ_FLAG);
    wr_cnt_lo   = wr_at(OFS_COUNT_LO) & !write_protect;
    wr_cnt_hi   = wr_at(OFS_COUNT_HI) & !write_protect;
    rd_set      = rd_at(OFS_IRQ_SET);
    wb_main     = wbyte_at(OFS_CTRL_MAIN);
    wb_capt     = wbyte_at(OFS_CTRL_CAPT);
    wb_clr      = wbyte_at(OFS_IRQ_CLR);
    wb_set      = wbyte_at(OFS_IRQ_SET);
    wb_flag     = wbyte_at(OFS_IRQ_FLAG);
    wb_cnt_lo   = wbyte_at(OFS_COUNT_LO);
    wb_cnt_hi   = wbyte_at(OFS_COUNT_HI);
    for (int c = 0; c < NUM_CH; c++) begin
      rd_cc[c]    = rd_at(OFS_CC_BASE + ADDR_W'(2 * c))
                  | rd_at(OFS_CC_BASE + ADDR_W'(2 * c + 1));
      cc_wr_lo[c] = wr_at(OFS_CC_BASE + ADDR_W'(2 * c)) & !write_protect;
      cc_wr_hi[c] = wr_at(OFS_CC_BASE + ADDR_W'(2 * c + 1)) & !write_protect;
      cc_wdata[c] = {wbyte_at(OFS_CC_BASE + ADDR_W'(2 * c + 1)),
                     wbyte_at(OFS_CC_BASE + ADDR_W'(2 * c))};
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      timer_channel u_ch (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .soft_clear   (soft_q),
        .tick         (tick_q),
        .run          (enable_q),
        .count        (count_q),
        .capture_mode (capt_mode_q[ch]),
        .capture_ev   (capture_in[ch]),
        .flag_set     (flag_q[BIT_MC0 + ch]),
        .wr_en        ({cc_wr_hi[ch], cc_wr_lo[ch]}),
        .wr_data      (cc_wdata[ch]),
        .cc_value     (cc_value[ch]),
        .hit          (match_hit[ch]),
        .overrun      (overrun[ch]),
        .busy         (cc_busy[ch])
      );
    end
  endgenerate
  // Counter clock tick, prescaler and counter.
  always_comb begin
    div_d      = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
    tick_d     = (div_q == DIV_LAST);
    count_d    = count_q;
    cnt_pend_d = (sync_q == SYNC_WAIT) ? cnt_pend_q : count_q;
    sync_d     = sync_q;
    ovf_hit    = 1'b0;
    if (wr_cnt_lo) begin
      cnt_pend_d[7:0] = wb_cnt_lo;
    end
    if (wr_cnt_hi) begin
      cnt_pend_d[15:8] = wb_cnt_hi;
    end
    unique case (sync_q)
      SYNC_IDLE: begin
        if (wr_cnt_lo || wr_cnt_hi) begin
          sync_d = SYNC_WAIT;
        end
      end
      SYNC_WAIT: begin
        // R13 count write crosses on tick
        if (tick_q && !(wr_cnt_lo || wr_cnt_hi)) begin
          sync_d = SYNC_IDLE;
        end
      end
    endcase
    if (tick_q) begin
      if (sync_q == SYNC_WAIT) begin
        count_d = cnt_pend_q;
      end else if (enable_q) begin
        count_d = count_q + 1'b1;
        // R17 wrap raises overflow
        ovf_hit = (count_q == CNT_TOP);
      end
    end
    if (soft_q) begin
      div_d      = '0;
      tick_d     = 1'b0;
      count_d    = '0;
      cnt_pend_d = '0;
      sync_d     = SYNC_IDLE;
    end
  end

  // Control, enables, flags and read data.
  always_comb begin
    enable_d    = enable_q;
    capt_mode_d = capt_mode_q;
    soft_d      = wr_main & wb_main[BIT_SWRST];
    if (wr_main) begin
      enable_d = wb_main[BIT_ENABLE];
    end
    if (wr_capt) begin
      capt_mode_d = wb_capt[NUM_CH-1:0];
    end
    // R7 R8 R16 set and clear enables
    int_en_d = (int_en_q & ~(wb_clr & FLAG_MASK & {8{wr_clr}}))
             | (wb_set & FLAG_MASK & {8{wr_set}});
    // R3 R6 write one clears
    flag_d = flag_q & ~(wb_flag & FLAG_MASK & {8{wr_flag}});
    for (int c = 0; c < NUM_CH; c++) begin
      // R4 capture read clears flag
      if (rd_cc[c] && capt_mode_q[c]) begin
        flag_d[BIT_MC0 + c] = 1'b0;
      end
    end
    // R1 R5 R17 sets win over clears
    if (ovf_hit) begin
      flag_d[BIT_OVF] = 1'b1;
    end
    if (|overrun) begin
      flag_d[BIT_ERR] = 1'b1;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (match_hit[c]) begin
        flag_d[BIT_MC0 + c] = 1'b1;
      end
    end
    // R9 R11 per-lane read data
    for (int i = 0; i < 4; i++) begin
      rdata_d[8*i +: 8] = lane_rd[i] ? reg_byte(lane_addr[i]) : BYTE_RST;
    end
    // R18 software reset clears
    if (soft_q) begin
      enable_d    = 1'b0;
      capt_mode_d = '0;
      int_en_d    = BYTE_RST;
      flag_d      = BYTE_RST;
      soft_d      = 1'b0;
    end
    // R2 R15 gated interrupt request
    irq_d = |(flag_d & int_en_d);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enable_q    <= 1'b0;
      soft_q      <= 1'b0;
      capt_mode_q <= '0;
      int_en_q    <= BYTE_RST;
      flag_q      <= BYTE_RST;
      count_q     <= '0;
      cnt_pend_q  <= '0;
      div_q       <= '0;
      tick_q      <= 1'b0;
      sync_q      <= SYNC_IDLE;
      rdata_q     <= '0;
      irq_q       <= 1'b0;
    end else begin
      enable_q    <= enable_d;
      soft_q      <= soft_d;
      capt_mode_q <= capt_mode_d;
      int_en_q    <= int_en_d;
      flag_q      <= flag_d;
      count_q     <= count_d;
      cnt_pend_q  <= cnt_pend_d;
      div_q       <= div_d;
      tick_q      <= tick_d;
      sync_q      <= sync_d;
      rdata_q     <= rdata_d;
      irq_q       <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign irq   = irq_q;
  localparam int SYNC_MAX = 8;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence mc0_clear_s;
    wr_flag && wb_flag[BIT_MC0] && !match_hit[0] && !soft_q;
  endsequence
  sequence match0_s;
    tick_q && enable_q && !capt_mode_q[0] && count_q == cc_value[0];
  endsequence
  sequence cnt_write_s;
    (wr_cnt_lo || wr_cnt_hi) && !soft_q;
  endsequence

  flag_set_a: assert property (match_hit[0] && !soft_q |=> flag_q[BIT_MC0]) // R1
    else $error("match hit did not set channel flag");
  flag_delay_a: assert property (match0_s ##1 !soft_q |=> flag_q[BIT_MC0]) // R2
    else $error("compare match flag not set after tick");
  irq_gate_a: assert property (irq_q == (|(flag_q & int_en_q))) // R15
    else $error("interrupt disagrees with flags and enables");
  w1c_clear_a: assert property (mc0_clear_s |=> !flag_q[BIT_MC0]) // R3
    else $error("write one did not clear channel flag");
  w0_keep_a: assert property (wr_flag && !wb_flag[BIT_MC0] && // R3
    flag_q[BIT_MC0] && !rd_cc[0] && !soft_q |=> flag_q[BIT_MC0])
    else $error("write zero changed channel flag");
  read_clear_a: assert property (rd_cc[0] && capt_mode_q[0] && // R4
    !match_hit[0] && !soft_q |=> !flag_q[BIT_MC0])
    else $error("capture read did not clear flag");
  overrun_err_a: assert property (overrun[0] && !soft_q |-> // R5
    $past(flag_q[BIT_MC0]) ##1 flag_q[BIT_ERR])
    else $error("overrun without flag or error not set");
  err_clear_a: assert property (wr_flag && wb_flag[BIT_ERR] && // R6
    !(|overrun) && !soft_q |=> !flag_q[BIT_ERR])
    else $error("write one did not clear error flag");
  err_en_a: assert property (wr_set && wb_set[BIT_ERR] && !soft_q // R7
    |=> int_en_q[BIT_ERR])
    else $error("error enable not set");
  ovf_en_a: assert property (wr_set && !wr_clr && !soft_q |=> // R8
    int_en_q[BIT_OVF] == ($past(int_en_q[BIT_OVF]) | $past(wb_set[BIT_OVF])))
    else $error("overflow enable set wrongly");
  en_read_a: assert property (rd_set |=> // R9
    rdata_q[15:8] == $past(int_en_q))
    else $error("enable read-back wrong");
  half_read_a: assert property (rd_at(OFS_COUNT_LO) && rd_at(OFS_COUNT_HI) // R10
    |=> rdata_q[15:0] == $past(count_q))
    else $error("half-word count read wrong");
  lane_zero_a: assert property (rd_stb && !byte_en[2] |=> // R11
    rdata_q[23:16] == 8'h00)
    else $error("unselected byte lane not zero");
  wp_block_a: assert property (wr_capt_raw && write_protect && !soft_q // R12
    |=> $stable(capt_mode_q))
    else $error("locked register accepted write");
  sync_cnt_a: assert property (cnt_write_s |=> sync_q == SYNC_WAIT // R13
    ##[0:SYNC_MAX] sync_q == SYNC_IDLE)
    else $error("count write never crossed");
  en_prot_a: assert property (wr_capt_raw && enable_q && !soft_q // R14
    |=> $stable(capt_mode_q))
    else $error("capture mode written while enabled");
  en_clr_a: assert property (wr_clr && wb_clr[BIT_OVF] && // R16
    !(wr_set && wb_set[BIT_OVF]) && !soft_q |=> !int_en_q[BIT_OVF])
    else $error("clear register did not disable");
  ovf_wrap_a: assert property (tick_q && enable_q && sync_q == SYNC_IDLE // R17
    && count_q == CNT_TOP && !soft_q |=> flag_q[BIT_OVF] && count_q == '0)
    else $error("counter wrap missed overflow");
  soft_rst_a: assert property (soft_q |=> // R18
    flag_q == 8'h00 && int_en_q == 8'h00 && !irq_q)
    else $error("software reset left flags or enables");
endmodule
`default_nettype wire

// ### include/timer_pkg.sv
// Shared constants for the timer with compare/capture interrupt flags.
// Assumes one system clock; the counter clock is a divided tick of it.
`default_nettype none
package timer_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 2;
  localparam int CNT_W  = 16;

  // Byte offsets on the register port.
  localparam logic [ADDR_W-1:0] OFS_CTRL_MAIN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_CAPT = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SET   = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG  = 8'h0a;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0b;
  localparam logic [ADDR_W-1:0] OFS_COUNT_LO  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HI  = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_CC_BASE   = 8'h18;

  // Field positions.
  localparam int BIT_OVF       = 0;
  localparam int BIT_ERR       = 1;
  localparam int BIT_MC0       = 4;
  localparam int BIT_SWRST     = 0;
  localparam int BIT_ENABLE    = 1;
  localparam int BIT_SYNC_BUSY = 0;
  localparam logic [7:0] FLAG_MASK = 8'h33;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;

  // Counter clock is the system clock divided down.
  localparam int CLK_PERIOD_NS = 20;
  localparam int CNT_CLK_NS    = 80;
  localparam int CNT_DIV       = CNT_CLK_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = $clog2(CNT_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CNT_DIV - 1);

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b01,
    SYNC_WAIT = 2'b10
  } sync_state_t;
endpackage
`default_nettype wire

// ### logic/timer_channel.sv
// One compare/capture channel: holds its value and reports hits.
// Assumes tick is a one-cycle pulse of the counter clock.
`default_nettype none
module timer_channel (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        soft_clear,
  input  wire logic                        tick,
  input  wire logic                        run,
  input  wire logic [timer_pkg::CNT_W-1:0] count,
  input  wire logic                        capture_mode,
  input  wire logic                        capture_ev,
  input  wire logic                        flag_set,
  input  wire logic [1:0]                  wr_en,
  input  wire logic [timer_pkg::CNT_W-1:0] wr_data,
  output logic [timer_pkg::CNT_W-1:0]      cc_value,
  output logic                             hit,
  output logic                             overrun,
  output logic                             busy
);
  import timer_pkg::*;

  logic [CNT_W-1:0] cc_q, cc_d, pend_q, pend_d;
  logic             pend_v_q, pend_v_d, cap_q, cap_d;
  logic             hit_q, hit_d, ovr_q, ovr_d;

  always_comb begin
    cc_d     = cc_q;
    pend_d   = pend_v_q ? pend_q : cc_q;
    pend_v_d = pend_v_q | (|wr_en);
    cap_d    = cap_q | (capture_ev & capture_mode);
    hit_d    = 1'b0;
    ovr_d    = 1'b0;
    if (wr_en[0]) begin
      pend_d[7:0] = wr_data[7:0];
    end
    if (wr_en[1]) begin
      pend_d[15:8] = wr_data[15:8];
    end
    if (tick) begin
      // R13 write applied on tick
      if (pend_v_q) begin
        cc_d     = pend_q;
        pend_v_d = |wr_en;
      end
      if (run && capture_mode && cap_q) begin
        cap_d = capture_ev;
        // R5 no room for capture
        if (flag_set) begin
          ovr_d = 1'b1;
        end else begin
          // R1 valid capture stored
          cc_d  = count;
          hit_d = 1'b1;
        end
      end else if (run && !capture_mode && count == cc_q) begin
        // R1 compare match hit
        hit_d = 1'b1;
      end
    end
    // R18 software reset clears
    if (soft_clear) begin
      cc_d     = '0;
      pend_d   = '0;
      pend_v_d = 1'b0;
      cap_d    = 1'b0;
      hit_d    = 1'b0;
      ovr_d    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cc_q     <= '0;
      pend_q   <= '0;
      pend_v_q <= 1'b0;
      cap_q    <= 1'b0;
      hit_q    <= 1'b0;
      ovr_q    <= 1'b0;
    end else begin
      cc_q     <= cc_d;
      pend_q   <= pend_d;
      pend_v_q <= pend_v_d;
      cap_q    <= cap_d;
      hit_q    <= hit_d;
      ovr_q    <= ovr_d;
    end
  end

  assign cc_value = cc_q;
  assign hit      = hit_q;
  assign overrun  = ovr_q;
  assign busy     = pend_v_q;
endmodule
`default_nettype wire

// ### testbench/tb_timer_capture_interrupt_flags.sv
// Self-checking bench for the timer interrupt flag and enable block.
// Assumes the register port contract of the design and a 50 MHz clock.
`default_nettype none
module tb_timer_capture_interrupt_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  logic              clk_sys;
  logic              reset;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [3:0]        byte_en;
  logic              wr_stb;
  logic              rd_stb;
  logic [DATA_W-1:0] rdata;
  logic              write_protect;
  logic [NUM_CH-1:0] capture_in;
  logic              irq;
  int                err_total;
  int                tests_run;

  timer_capture_interrupt_flags timer_capture_interrupt_flags_inst (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .addr          (addr),
    .wdata         (wdata),
    .byte_en       (byte_en),
    .wr_stb        (wr_stb),
    .rd_stb        (rd_stb),
    .rdata         (rdata),
    .write_protect (write_protect),
    .capture_in    (capture_in),
    .irq           (irq)
  );

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge clk_sys);
    addr    <= {a[7:2], 2'b00};
    byte_en <= be;
    wdata   <= d;
    wr_stb  <= 1'b1;
    @(posedge clk_sys);
    wr_stb  <= 1'b0;
  endtask

  // The read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [3:0] be,
                    output logic [31:0] w);
    @(posedge clk_sys);
    addr    <= {a[7:2], 2'b00};
    byte_en <= be;
    rd_stb  <= 1'b1;
    @(posedge clk_sys);
    rd_stb  <= 1'b0;
    #1;
    w = rdata;
  endtask

  task automatic wb(input logic [7:0] a, input logic [7:0] v);
    wr(a, 4'b0001 << a[1:0], {4{v}});
  endtask

  task automatic rb(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [31:0] w;
    rd(a, 4'b0001 << a[1:0], w);
    chk_val(nm, {24'h0, e}, {24'h0, w[{a[1:0], 3'b000} +: 8]});
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_bit("irq", e, irq);
  endtask

  task automatic capture(input logic [NUM_CH-1:0] ch);
    @(posedge clk_sys);
    capture_in <= ch;
    @(posedge clk_sys);
    capture_in <= '0;
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic t_reset_values();
    rb(OFS_IRQ_FLAG, 8'h00, "flags after reset");
    rb(OFS_IRQ_SET, 8'h00, "enables after reset");
    irq_is(1'b0);
  endtask

  // Counter wraps near its top; compare value 0 then matches on both channels.
  task automatic t_overflow_enables();
    wr(OFS_COUNT_LO, 4'b0011, 32'h0000_fffe);
    wb(OFS_CTRL_MAIN, 8'h02);
    repeat (40) @(posedge clk_sys);
    rb(OFS_IRQ_FLAG, 8'h31, "flags after wrap");
    irq_is(1'b0);
    wb(OFS_IRQ_SET, 8'h01);
    rb(OFS_IRQ_SET, 8'h01, "overflow enable");
    irq_is(1'b1);
    wb(OFS_IRQ_FLAG, 8'h00);
    rb(OFS_IRQ_FLAG, 8'h31, "flags after zero write");
    wb(OFS_IRQ_CLR, 8'h01);
    rb(OFS_IRQ_CLR, 8'h00, "enable after clear");
    irq_is(1'b0);
    wb(OFS_IRQ_SET, 8'h01);
    wb(OFS_IRQ_FLAG, 8'h01);
    rb(OFS_IRQ_FLAG, 8'h30, "overflow cleared");
    irq_is(1'b0);
    wb(OFS_IRQ_FLAG, 8'h10);
    rb(OFS_IRQ_FLAG, 8'h20, "channel 0 cleared");
    wb(OFS_IRQ_FLAG, 8'h20);
    wb(OFS_IRQ_CLR, 8'h01);
  endtask

  task automatic t_capture_error();
    logic [31:0] w;
    wb(OFS_CTRL_CAPT, 8'h03);
    rb(OFS_CTRL_CAPT, 8'h00, "mode write while enabled");
    wb(OFS_CTRL_MAIN, 8'h00);
    wb(OFS_CTRL_CAPT, 8'h03);
    rb(OFS_CTRL_CAPT, 8'h03, "mode write while disabled");
    wb(OFS_CTRL_MAIN, 8'h02);
    wb(OFS_IRQ_SET, 8'h12);
    rb(OFS_IRQ_SET, 8'h12, "error and channel enables");
    capture(2'b01);
    rb(OFS_IRQ_FLAG, 8'h10, "first capture");
    irq_is(1'b1);
    capture(2'b01);
    rb(OFS_IRQ_FLAG, 8'h12, "capture overrun");
    wb(OFS_IRQ_FLAG, 8'h02);
    rb(OFS_IRQ_FLAG, 8'h10, "error cleared");
    // Channel 1 has not captured yet; channel 0 took a running count.
    rd(OFS_CC_BASE, 4'hf, w);
    chk_val("cc1 before capture", 32'h0, {16'h0, w[31:16]});
    chk_bit("cc0 holds capture", 1'b1, |w[15:0]);
    rb(OFS_IRQ_FLAG, 8'h00, "flag after value read");
    irq_is(1'b0);
    capture(2'b10);
    rb(OFS_IRQ_FLAG, 8'h20, "channel 1 capture");
    irq_is(1'b0);
    wb(OFS_IRQ_SET, 8'h20);
    irq_is(1'b1);
    wb(OFS_IRQ_CLR, 8'h22);
    rb(OFS_IRQ_SET, 8'h10, "enables after clear");
    wb(OFS_CTRL_MAIN, 8'h00);
  endtask

  task automatic t_access_protect();
    logic [31:0] w;
    wr(OFS_COUNT_LO, 4'b0011, 32'h0000_1234);
    repeat (8) @(posedge clk_sys);
    rd(OFS_COUNT_LO, 4'b0011, w);
    chk_val("count half write", 32'h0000_1234, w);
    @(posedge clk_sys);
    write_protect <= 1'b1;
    wr(OFS_COUNT_LO, 4'b0011, 32'h0000_5678);
    repeat (8) @(posedge clk_sys);
    rd(OFS_COUNT_LO, 4'b0011, w);
    chk_val("count write protected", 32'h0000_1234, w);
    wb(OFS_CTRL_CAPT, 8'h00);
    rb(OFS_CTRL_CAPT, 8'h03, "mode write protected");
    wb(OFS_IRQ_SET, 8'h01);
    rb(OFS_IRQ_SET, 8'h11, "enable not protected");
    rd(OFS_IRQ_CLR, 4'hf, w);
    chk_val("word read", 32'h0020_1111, w);
    rb(8'h3c, 8'h00, "unmapped read");
    @(posedge clk_sys);
    write_protect <= 1'b0;
  endtask

  task automatic t_soft_reset();
    wb(OFS_CTRL_MAIN, 8'h01);
    repeat (3) @(posedge clk_sys);
    rb(OFS_IRQ_FLAG, 8'h00, "flags after soft reset");
    rb(OFS_IRQ_SET, 8'h00, "enables after soft reset");
    rb(OFS_CTRL_CAPT, 8'h00, "modes after soft reset");
    irq_is(1'b0);
  endtask

  initial begin
    #(CLK_PERIOD_NS * 5000);
    err_total++;
    $display("unexpected watchdog: expected finish seen hang");
    final_report();
  end

  initial begin
    clk_sys       = 1'b0;
    reset         = 1'b1;
    addr          = '0;
    wdata         = '0;
    byte_en       = '0;
    wr_stb        = 1'b0;
    rd_stb        = 1'b0;
    write_protect = 1'b0;
    capture_in    = '0;
    err_total     = 0;
    tests_run     = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_values();
    t_overflow_enables();
    t_capture_error();
    t_access_protect();
    t_soft_reset();
    final_report();
  end
endmodule
`default_nettype wire
